// *** port_pins.sv ***
`timescale 1ns/1ns
`include "gpio_map.svh"


module port_pins
(
   input  wire logic              clock,
   input  wire logic              sys_rst_n,
   input  wire gpio_pkg::reg_req_s req,
   output gpio_pkg::byte_t        rd_data,
   input  wire logic [7:0]        port0_in,
   input  wire logic [7:0]        port1_in,
   input  wire logic [6:0]        port2_in,
   input  wire logic [7:0]        port4_in,
   output gpio_pkg::pin_drive_s   port0_drive,
   output gpio_pkg::pin_drive_s   port1_drive,
   output gpio_pkg::pin_drive_s   port2_drive,
   output gpio_pkg::pin_drive_s   port4_drive,
   output logic [7:0]             port0_pullup,
   output logic [7:0]             port1_pullup,
   output logic [7:0]             port2_pullup,
   output logic [7:0]             port4_pullup,
   input  wire logic              serial_data_out,
   input  wire logic              serial_clock_out,
   input  wire logic              timer_out_pin,
   output logic                   serial_data_in,
   output logic                   serial_clock_pin,
   output logic                   timer_ext_clock_in,
   output logic                   irq
);

   import gpio_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [3:0][7:0] latch;
   logic [3:0][7:0] direction;
   logic [3:0]      pullup_option;
   logic [1:0]      output_type_sel_a;
   logic [7:0]      output_type_sel_b;
   logic [6:0]      port2_ctrl;
   logic [7:0]      port4_ctrl;
   logic [1:0]      edge_sel;
   logic [1:0]      irq_status;
   logic [1:0]      irq_mask;
   logic [3:0][7:0] pin_in;
   logic [3:0][7:0] valid;
   logic [3:0][7:0] next_val;
   logic [3:0][7:0] od_sel;
   logic [3:0][7:0] next_oe;
   logic [3:0][7:0] next_pull;
   logic [3:0][7:0] read_val;
   logic            ext_hit;
   logic            key_hit;
   logic [1:0]      events;
   logic [1:0]      clear_bits;
   logic [1:0]      next_mask;
   logic [7:0]      next_rd;

   assign pin_in[PORT_0] = port0_in;
   assign pin_in[PORT_1] = port1_in;
   assign pin_in[PORT_2] = {1'b0, port2_in};
   assign pin_in[PORT_4] = port4_in;
   assign valid[PORT_0]  = 8'hFF;
   assign valid[PORT_1]  = 8'hFF;
   assign valid[PORT_2]  = `PORT2_MASK;
   assign valid[PORT_4]  = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
      begin
         latch     <= '0;
         direction <= {4{`RST_DIR}};
      end
      else if (req.wr)
      begin
         case (req.addr)
            `OFS_PORT0: latch[PORT_0]     <= req.wdata;
            `OFS_PORT1: latch[PORT_1]     <= req.wdata;
            `OFS_PORT2: latch[PORT_2]     <= req.wdata & `PORT2_MASK;
            `OFS_PORT4: latch[PORT_4]     <= req.wdata;
            `OFS_DIR0:  direction[PORT_0] <= req.wdata;
            `OFS_DIR1:  direction[PORT_1] <= req.wdata;
            `OFS_DIR2:  direction[PORT_2] <= req.wdata | ~`PORT2_MASK;
            `OFS_DIR4:  direction[PORT_4] <= req.wdata;
            default:    ;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
      begin
         pullup_option     <= '0;
         output_type_sel_a <= '0;
         output_type_sel_b <= `RST_ZERO;
         port2_ctrl        <= '0;
         port4_ctrl        <= `RST_ZERO;
         edge_sel          <= '0;
         irq_mask          <= '0;
      end
      else if (req.wr)
      begin
         case (req.addr)
            `OFS_PULLUP:   pullup_option     <= req.wdata[3:0];
            `OFS_OTYPE_A:  output_type_sel_a <= req.wdata[1:0];
            `OFS_OTYPE_B:  output_type_sel_b <= req.wdata & 8'h60;
            `OFS_CTRL2:    port2_ctrl        <= req.wdata[6:0];
            `OFS_CTRL4:    port4_ctrl        <= req.wdata;
            `OFS_EDGE:     edge_sel          <= req.wdata[1:0];
            `OFS_IRQ_MASK: irq_mask          <= req.wdata[1:0];
            default:       ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive, one slice per port
   // Open-drain choice per bit, spread from the per-port and per-bit settings
   assign od_sel[PORT_0] = {8{output_type_sel_a[`OTA_PORT0]}};
   assign od_sel[PORT_1] = {8{output_type_sel_a[`OTA_PORT1]}};
   assign od_sel[PORT_2] = output_type_sel_b & 8'h60;
   assign od_sel[PORT_4] = 8'h00;

   // Control mode swaps in peripheral outputs; direction still gates the drive
   always_comb
   begin
      next_val = latch;
      if (port2_ctrl[`CTL2_SCLK])
         next_val[PORT_2][`CTL2_SCLK] = serial_clock_out;
      if (port2_ctrl[`CTL2_SDO])
         next_val[PORT_2][`CTL2_SDO] = serial_data_out;
      if (port2_ctrl[`CTL2_TIMER])
         next_val[PORT_2][`CTL2_TIMER] = timer_out_pin;
   end

   generate
      for (genvar p = 0; p < 4; p++)
      begin : g_port
         // Open drain only releases the pin for a one, never drives high
         assign next_oe[p]   = valid[p] & ~direction[p] & (~od_sel[p] | ~next_val[p]);
         assign next_pull[p] = valid[p] & direction[p] & {8{pullup_option[p]}};
         assign read_val[p]  = valid[p] & ((direction[p] & pin_in[p])
                                         | (~direction[p] & latch[p]));
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
      begin
         port0_drive <= '0;
         port1_drive <= '0;
         port2_drive <= '0;
         port4_drive <= '0;
      end
      else
      begin
         port0_drive <= '{out: next_val[PORT_0], oe: next_oe[PORT_0]};
         port1_drive <= '{out: next_val[PORT_1], oe: next_oe[PORT_1]};
         port2_drive <= '{out: next_val[PORT_2] & `PORT2_MASK, oe: next_oe[PORT_2]};
         port4_drive <= '{out: next_val[PORT_4], oe: next_oe[PORT_4]};
      end
   end

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
      begin
         port0_pullup <= '0;
         port1_pullup <= '0;
         port2_pullup <= '0;
         port4_pullup <= '0;
      end
      else
      begin
         port0_pullup <= next_pull[PORT_0];
         port1_pullup <= next_pull[PORT_1];
         port2_pullup <= next_pull[PORT_2];
         port4_pullup <= next_pull[PORT_4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Peripheral inputs from port 2
   // Unselected functions read low so a peripheral never sees port traffic
   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
      begin
         serial_data_in     <= 1'b0;
         serial_clock_pin   <= 1'b0;
         timer_ext_clock_in <= 1'b0;
      end
      else
      begin
         serial_data_in     <= port2_ctrl[`CTL2_SDI] & port2_in[`CTL2_SDI];
         serial_clock_pin   <= port2_ctrl[`CTL2_SCLK] & port2_in[`CTL2_SCLK];
         timer_ext_clock_in <= port2_ctrl[`CTL2_TIMER] & port2_in[`CTL2_TIMER];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Edge and key-return detection
   edge_sense #(
      .WIDTH (1)
   ) u_ext_edge (
      .clock     (clock),
      .sys_rst_n (sys_rst_n),
      .level     (port2_in[`CTL2_TIMER]),
      .enable    (port2_ctrl[`CTL2_TIMER]),
      .rise_en   (edge_sel[`EDGE_RISE]),
      .fall_en   (edge_sel[`EDGE_FALL]),
      .hit       (ext_hit)
   );

   // Keys pull low when pressed, so only falls count
   edge_sense #(
      .WIDTH (8)
   ) u_key_edge (
      .clock     (clock),
      .sys_rst_n (sys_rst_n),
      .level     (port4_in),
      .enable    (port4_ctrl),
      .rise_en   (1'b0),
      .fall_en   (1'b1),
      .hit       (key_hit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, a new event wins over the clear
   assign events     = {key_hit, ext_hit};
   assign clear_bits = (req.wr && req.addr == `OFS_IRQ_STATUS) ? req.wdata[1:0] : 2'b00;
   // Mask taken ahead so the level never lags a mask write
   assign next_mask  = (req.wr && req.addr == `OFS_IRQ_MASK) ? req.wdata[1:0] : irq_mask;

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~clear_bits) | events;
   end

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
         irq <= 1'b0;
      else
         irq <= |(((irq_status & ~clear_bits) | events) & next_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads, data one cycle after the strobe, zero elsewhere
   always_comb
   begin
      next_rd = 8'h00;
      case (req.addr)
         `OFS_PORT0:      next_rd = read_val[PORT_0];
         `OFS_PORT1:      next_rd = read_val[PORT_1];
         `OFS_PORT2:      next_rd = read_val[PORT_2];
         `OFS_PORT4:      next_rd = read_val[PORT_4];
         `OFS_DIR0:       next_rd = direction[PORT_0];
         `OFS_DIR1:       next_rd = direction[PORT_1];
         `OFS_DIR2:       next_rd = direction[PORT_2] & `PORT2_MASK;
         `OFS_DIR4:       next_rd = direction[PORT_4];
         `OFS_PULLUP:     next_rd = {4'h0, pullup_option};
         `OFS_OTYPE_A:    next_rd = {6'h00, output_type_sel_a};
         `OFS_OTYPE_B:    next_rd = output_type_sel_b;
         `OFS_CTRL2:      next_rd = {1'b0, port2_ctrl};
         `OFS_CTRL4:      next_rd = port4_ctrl;
         `OFS_EDGE:       next_rd = {6'h00, edge_sel};
         `OFS_IRQ_STATUS: next_rd = {6'h00, irq_status};
         `OFS_IRQ_MASK:   next_rd = {6'h00, irq_mask};
         default:         next_rd = 8'h00;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
         rd_data <= 8'h00;
      else if (req.rd)
         rd_data <= next_rd;
      else
         rd_data <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!sys_rst_n);

   property no_drive_after_reset;
      @(posedge clock) disable iff (1'b0)
      $rose(sys_rst_n) |-> (port0_drive.oe == 8'h00 && port1_drive.oe == 8'h00
                         && port2_drive.oe == 8'h00 && port4_drive.oe == 8'h00);
   endproperty
   reset_all_input_a: assert property (no_drive_after_reset)
      else $error("pin driven right after reset");
   held_reset_a: assert property (@(posedge clock) disable iff (1'b0)
      !sys_rst_n |=> (irq == 1'b0 && rd_data == 8'h00))
      else $error("outputs active during reset");
   port0_dir_a: assert property (port0_drive.oe != 8'h00 |->
      ($past(direction[PORT_0]) & port0_drive.oe) == 8'h00)
      else $error("port 0 drives an input bit");
   port1_dir_a: assert property (port1_drive.oe != 8'h00 |->
      ($past(direction[PORT_1]) & port1_drive.oe) == 8'h00)
      else $error("port 1 drives an input bit");
   port2_width_a: assert property (port2_drive.oe[7] == 1'b0 && port2_pullup[7] == 1'b0)
      else $error("port 2 bit 7 active");
   port4_dir_a: assert property (req.wr && req.addr == `OFS_DIR4 ##1 !req.wr
      |=> port4_drive.oe == (~$past(req.wdata, 2) & ~od_sel[PORT_4]))
      else $error("port 4 direction not followed");
   pullup_input_a: assert property ((port0_pullup & port0_drive.oe) == 8'h00
      && (port4_pullup & port4_drive.oe) == 8'h00)
      else $error("pull-up on an output pin");
   open_drain_a: assert property ((port0_drive.oe & port0_drive.out) != 8'h00
      |-> !$past(output_type_sel_a[`OTA_PORT0]))
      else $error("open-drain port 0 drove high");
   bit5_od_a: assert property (port2_drive.oe[5] && port2_drive.out[5]
      |-> !$past(output_type_sel_b[`OTB_BIT5]))
      else $error("open-drain bit 5 drove high");
   serial_in_a: assert property (port2_ctrl[`CTL2_SDI] && $stable(port2_ctrl)
      |=> serial_data_in == $past(port2_in[`CTL2_SDI]))
      else $error("serial data input not passed");
   timer_in_a: assert property (!port2_ctrl[`CTL2_TIMER] |=> !timer_ext_clock_in)
      else $error("timer clock leaks in port mode");
   ext_edge_a: assert property (port2_ctrl[`CTL2_TIMER] && edge_sel[`EDGE_RISE]
      && $rose(port2_in[`CTL2_TIMER]) |-> ##2 irq_status[`IRQ_EXT])
      else $error("rising edge not flagged");
   key_fall_a: assert property (port4_ctrl[0] && $fell(port4_in[0])
      |-> ##2 irq_status[`IRQ_KEY])
      else $error("key press not flagged");
   read_latch_a: assert property (req.rd && req.addr == `OFS_PORT1
      |=> rd_data == $past(read_val[PORT_1]))
      else $error("port 1 read wrong");

   ext_cov: cover property (ext_hit ##1 irq);
   key_cov: cover property (key_hit ##1 irq_status[`IRQ_KEY]);
   od_cov: cover property (output_type_sel_a[`OTA_PORT0] && port0_drive.oe != 8'h00);
   serial_cov: cover property (port2_ctrl[`CTL2_SDO] && port2_drive.oe[`CTL2_SDO]);

endmodule

// *** gpio_map.svh ***
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// Register offsets, byte addresses on the 8-bit register port
`define OFS_PORT0        8'h00
`define OFS_PORT1        8'h01
`define OFS_PORT2        8'h02
`define OFS_PORT4        8'h03
`define OFS_DIR0         8'h04
`define OFS_DIR1         8'h05
`define OFS_DIR2         8'h06
`define OFS_DIR4         8'h07
`define OFS_PULLUP       8'h08
`define OFS_OTYPE_A      8'h09
`define OFS_OTYPE_B      8'h0A
`define OFS_CTRL2        8'h0B
`define OFS_CTRL4        8'h0C
`define OFS_EDGE         8'h0D
`define OFS_IRQ_STATUS   8'h0E
`define OFS_IRQ_MASK     8'h0F

// Reset values
`define RST_DIR          8'hFF
`define RST_ZERO         8'h00

// Port 2 has seven pins
`define PORT2_MASK       8'h7F

// Field positions
`define OTA_PORT0        0
`define OTA_PORT1        1
`define OTB_BIT5         5
`define OTB_BIT6         6
`define CTL2_SCLK        0
`define CTL2_SDO         1
`define CTL2_SDI         2
`define CTL2_TIMER       6
`define EDGE_RISE        0
`define EDGE_FALL        1
`define IRQ_EXT          0
`define IRQ_KEY          1

`endif

// *** gpio_pkg.sv ***
package gpio_pkg;

   // Index of each port in the internal port arrays
   typedef enum logic [1:0] {
      PORT_0,
      PORT_1,
      PORT_2,
      PORT_4
   } port_idx_e;

   // Drive of one 8-bit group of two-way pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_s;

   // One access on the register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef logic [7:0] byte_t;

endpackage

// *** edge_sense.sv ***
`timescale 1ns/1ns

module edge_sense #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             sys_rst_n,
   input  wire logic [WIDTH-1:0] level,
   input  wire logic [WIDTH-1:0] enable,
   input  wire logic             rise_en,
   input  wire logic             fall_en,
   output logic                  hit
);

   logic [WIDTH-1:0] prev;

   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
         prev <= '0;
      else
         prev <= level;
   end

   // Disabled bits never hit, so turning a pin on cannot fake an edge
   always_ff @(posedge clock)
   begin
      if (!sys_rst_n)
         hit <= 1'b0;
      else
         hit <= |(enable & (({WIDTH{rise_en}} & level & ~prev)
                          | ({WIDTH{fall_en}} & ~level & prev)));
   end

endmodule

// *** pin_env.sv ***
`timescale 1ns/1ns

module pin_env
(
   input  wire logic                       clock,
   input  wire gpio_pkg::pin_drive_s [3:0] drv,
   input  wire logic [3:0][7:0]            pu,
   input  wire logic [3:0][7:0]            ev,
   input  wire logic [3:0][7:0]            ee,
   output logic [3:0][7:0]                 lvl
);
   import gpio_pkg::*;

   logic flip = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Floating pins wander so a stale value never passes for a pull-up
   always_ff @(posedge clock)
      flip <= ~flip;

   ////////////////////////////////////////////////////////////////////////////
   // Pin wire: chip drive, then outside driver, then pull-up
   always_comb
      for (int p = 0; p < 4; p++)
         for (int b = 0; b < 8; b++)
            if (drv[p].oe[b])
               lvl[p][b] = drv[p].out[b];
            else if (ee[p][b])
               lvl[p][b] = ev[p][b];
            else if (pu[p][b])
               lvl[p][b] = 1'b1;
            else
               lvl[p][b] = flip ^ b[0];
endmodule

// *** port_pins_bench.sv ***
`timescale 1ns/1ns
`include "gpio_map.svh"

module port_pins_bench;
   import gpio_pkg::*;

   logic             clock;
   logic             sys_rst_n;
   reg_req_s         req;
   byte_t            rd_data;
   pin_drive_s [3:0] pdrv;
   logic [3:0][7:0]  pu;
   logic [3:0][7:0]  lvl;
   logic [3:0][7:0]  ev;
   logic [3:0][7:0]  ee;
   logic             sdo;
   logic             sck;
   logic             tmo;
   logic             sdi;
   logic             scp;
   logic             tci;
   logic             irq;
   logic             rd_d;
   byte_t            exp_q [$];
   byte_t            dk [4];
   byte_t            mk [4];
   byte_t            d;
   byte_t            v;
   int               err_count;
   int               total_checks;
   integer           seed;

   port_pins port_pins_inst (.clock(clock), .sys_rst_n(sys_rst_n), .req(req),
      .rd_data(rd_data), .port0_in(lvl[0]), .port1_in(lvl[1]), .port2_in(lvl[2][6:0]),
      .port4_in(lvl[3]), .port0_drive(pdrv[0]), .port1_drive(pdrv[1]),
      .port2_drive(pdrv[2]), .port4_drive(pdrv[3]), .port0_pullup(pu[0]),
      .port1_pullup(pu[1]), .port2_pullup(pu[2]), .port4_pullup(pu[3]),
      .serial_data_out(sdo), .serial_clock_out(sck), .timer_out_pin(tmo),
      .serial_data_in(sdi), .serial_clock_pin(scp), .timer_ext_clock_in(tci), .irq(irq));

   pin_env pin_env_inst (.clock(clock), .drv(pdrv), .pu(pu), .ev(ev), .ee(ee), .lvl(lvl));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Idle cycle after each access keeps one assignment per time step
   task automatic acc(input logic w, input byte_t a, input byte_t x);
      req <= '{wr: w, rd: ~w, addr: a, wdata: x};
      tick(1);
      req <= '0;
      tick(1);
   endtask

   task automatic wr(input byte_t a, input byte_t x);
      acc(1'b1, a, x);
   endtask

   task automatic rd(input byte_t a, input byte_t e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   function automatic byte_t wm(input int p);
      return (p == 2) ? `PORT2_MASK : 8'hFF;
   endfunction

   task automatic test_done;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe
   always @(posedge clock)
      rd_d <= req.rd & sys_rst_n;

   always @(negedge clock)
      if (rd_d && exp_q.size() > 0)
         chk(rd_data, exp_q.pop_front());

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 32'h53d1_7044;
      err_count = 0;
      total_checks = 0;
      sys_rst_n = 1'b0;
      req = '0;
      ev = '0;
      ee = '1;
      sdo = 1'b0;
      sck = 1'b0;
      tmo = 1'b0;
      tick(5);
      chk(pdrv[0].oe | pdrv[3].oe | pu[0], 8'h00);
      sys_rst_n <= 1'b1;
      tick(1);
      for (int p = 0; p < 4; p++)
         rd(byte_t'(`OFS_DIR0 + p), `RST_DIR & wm(p));
      rd(`OFS_IRQ_MASK, 8'h00);
      rd(8'h20, 8'h00);
      // Random latch, direction and outside levels per port
      for (int p = 0; p < 4; p++)
      begin
         dk[p] = byte_t'($random(seed));
         mk[p] = byte_t'($random(seed));
         d = byte_t'($random(seed));
         ev[p] <= d;
         wr(byte_t'(`OFS_PORT0 + p), dk[p]);
         wr(byte_t'(`OFS_DIR0 + p), mk[p]);
         tick(1);
         chk(pdrv[p].oe, ~mk[p] & wm(p));
         chk(pdrv[p].out & ~mk[p] & wm(p), dk[p] & ~mk[p] & wm(p));
         rd(byte_t'(`OFS_PORT0 + p), ((dk[p] & ~mk[p]) | (d & mk[p])) & wm(p));
      end
      // Pull-ups follow each port's option bit and the direction
      ee <= '0;
      for (int i = 0; i < 2; i++)
      begin
         v = i ? 8'h0F : 8'h05;
         wr(`OFS_PULLUP, v);
         tick(1);
         for (int p = 0; p < 4; p++)
            chk(pu[p], v[p] ? (mk[p] & wm(p)) : 8'h00);
      end
      for (int p = 0; p < 4; p++)
         rd(byte_t'(`OFS_PORT0 + p), ((dk[p] & ~mk[p]) | mk[p]) & wm(p));
      ee <= '1;
      // Open drain releases the pin for a one
      wr(`OFS_OTYPE_A, 8'h01);
      wr(`OFS_PORT0, 8'h55);
      wr(`OFS_DIR0, 8'h00);
      wr(`OFS_PORT1, 8'h0F);
      wr(`OFS_DIR1, 8'h00);
      tick(1);
      chk(pdrv[0].oe, 8'hAA);
      chk(pdrv[1].oe, 8'hFF);
      wr(`OFS_OTYPE_A, 8'h02);
      tick(1);
      chk(pdrv[0].oe, 8'hFF);
      chk(pdrv[1].oe, 8'hF0);
      wr(`OFS_PORT2, 8'h7F);
      wr(`OFS_DIR2, 8'h00);
      wr(`OFS_OTYPE_B, 8'h60);
      tick(1);
      chk(pdrv[2].oe, 8'h1F);
      wr(`OFS_OTYPE_B, 8'h40);
      tick(1);
      chk(pdrv[2].oe, 8'h3F);
      wr(`OFS_OTYPE_B, 8'h00);
      // Serial functions on port 2
      wr(`OFS_PORT2, 8'h00);
      wr(`OFS_DIR2, 8'h7C);
      ev[2] <= 8'h04;
      sdo <= 1'b1;
      wr(`OFS_CTRL2, 8'h07);
      tick(1);
      chk({6'h00, pdrv[2].oe[1:0], pdrv[2].out[1:0]}, 8'h0E);
      chk({7'h00, sdi}, 8'h01);
      sdo <= 1'b0;
      sck <= 1'b1;
      tick(2);
      chk({6'h00, pdrv[2].out[1:0]}, 8'h01);
      sdo <= 1'b1;
      wr(`OFS_CTRL2, 8'h05);
      tick(1);
      chk({7'h00, pdrv[2].out[1]}, 8'h00);
      wr(`OFS_DIR2, 8'h7D);
      ev[2] <= 8'h05;
      tick(2);
      chk({7'h00, scp}, 8'h01);
      wr(`OFS_CTRL2, 8'h00);
      tick(1);
      chk({6'h00, scp, sdi}, 8'h00);
      // Timer shares bit 6
      wr(`OFS_CTRL2, 8'h40);
      wr(`OFS_DIR2, 8'h3F);
      tmo <= 1'b1;
      tick(2);
      chk({7'h00, pdrv[2].out[6]}, 8'h01);
      wr(`OFS_DIR2, 8'h7F);
      ev[2] <= 8'h40;
      tick(2);
      chk({7'h00, tci}, 8'h01);
      // External interrupt, edge selections 1 to 3 (rise, fall, both)
      wr(`OFS_IRQ_MASK, 8'h01);
      for (int md = 1; md < 4; md++)
      begin
         wr(`OFS_EDGE, byte_t'(md));
         ev[2][6] <= 1'b0;
         tick(3);
         wr(`OFS_IRQ_STATUS, 8'h03);
         tick(1);
         ev[2][6] <= 1'b1;
         tick(3);
         chk({7'h00, irq}, {7'h00, md[0]});
         rd(`OFS_IRQ_STATUS, {7'h00, md[0]});
         wr(`OFS_IRQ_STATUS, 8'h01);
         tick(1);
         ev[2][6] <= 1'b0;
         tick(3);
         chk({7'h00, irq}, {7'h00, md[1]});
      end
      // Key return on port 4 bit 0 only
      wr(`OFS_CTRL4, 8'h01);
      wr(`OFS_DIR4, 8'hFF);
      ev[3] <= 8'hFF;
      wr(`OFS_IRQ_MASK, 8'h02);
      wr(`OFS_IRQ_STATUS, 8'h03);
      tick(1);
      ev[3] <= 8'hFE;
      tick(3);
      chk({7'h00, irq}, 8'h01);
      wr(`OFS_IRQ_MASK, 8'h00);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      rd(`OFS_IRQ_STATUS, 8'h02);
      wr(`OFS_IRQ_STATUS, 8'h02);
      ev[3] <= 8'hFD;
      tick(3);
      rd(`OFS_IRQ_STATUS, 8'h00);
      // Reset in mid-run
      sys_rst_n <= 1'b0;
      tick(2);
      sys_rst_n <= 1'b1;
      tick(1);
      chk(pdrv[0].oe | pdrv[2].oe, 8'h00);
      rd(`OFS_DIR0, `RST_DIR);
      rd(`OFS_OTYPE_A, 8'h00);
      for (int i = 0; i < 10 && exp_q.size() > 0; i++)
         tick(1);
      if (exp_q.size() > 0)
         err_count++;
      test_done();
   end
endmodule
